// ==== src/ogp_map.svh ====
// Register map, field layout, reset values and timing counts of the pin boot configuration
// Overview of operation
// - Bit 15 picks input (1) or output (0); bit 8 low tri-states the pin.
// - Bits 14:13 pick no pull, pull-down or pull-up; code 11 gives none.
// - Bit 12 low: interrupt on active edge only; high: on both edges.
// - Bit 11 picks the pin supply: digital buffer (0) or main system (1).
// - Bit 10 low inverts the pin (active low); high keeps it active high.
// - Bit 9 picks push-pull (0) or open-drain (1) output driver.
// - Input codes 0-5: long-debounce input, input, on/off, sleep/wake, long sleep/wake, sleep.
// - Input codes 6-15: power on, watchdog, scaling selects, hw enables, hw controls.
// - Output codes 0-4: output value, 32 kHz clock, on, sleep, state change; 5-7 reserved.
// - Output codes 8-15: scaling done, power enables, supply good, power good, clock, reset.
// - Pin 6 bits 3:1 set rising supply-good level, 2.8 V plus 0.1 V per step.
// - Supply good asserts only at or above threshold plus hysteresis margin.
// - In development mode an ON request accepts the image only if check word is a596.
`ifndef OGP_MAP_SVH
`define OGP_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OGP_IDX_PIN5 16'h781e
`define OGP_IDX_PIN6 16'h781f
`define OGP_IDX_CHECK 16'h7827
`define OGP_IDX_IRQ_STAT 16'h7830
`define OGP_IDX_IRQ_MASK 16'h7831
`define OGP_IDX_PIN_OUT 16'h7832
`define OGP_IDX_PIN_STATE 16'h7833

// ----------------------------------------------------------------
// Pin word fields
// ----------------------------------------------------------------
`define OGP_DIR_BIT 15
`define OGP_PULL_HI 14
`define OGP_PULL_LO 13
`define OGP_IRQ_MODE_BIT 12
`define OGP_DOMAIN_BIT 11
`define OGP_POL_BIT 10
`define OGP_OD_BIT 9
`define OGP_ENA_BIT 8
`define OGP_FN_HI 7
`define OGP_FN_LO 4
`define OGP_THR_HI 3
`define OGP_THR_LO 1
`define OGP_PIN5_MASK 16'hfff0
`define OGP_PIN6_MASK 16'hfffe
`define OGP_PIN5_RST 16'ha400
`define OGP_PIN6_RST 16'ha40a
`define OGP_CHECK_RST 16'h0000
`define OGP_CHECK_VALUE 16'ha596

// ----------------------------------------------------------------
// Supply good threshold in millivolts
// ----------------------------------------------------------------
`define OGP_THR_BASE_MV 13'h0af0
`define OGP_THR_STEP_MV 13'h0064
`define OGP_HYST_MV 13'h0032

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OGP_CLK_MHZ 250
`define OGP_DEB_SHORT_NS 1000
`define OGP_DEB_SHORT_CYC ((`OGP_DEB_SHORT_NS * `OGP_CLK_MHZ + 999) / 1000)
`define OGP_DEB_LONG_US 10000
`define OGP_DEB_LONG_CYC (`OGP_DEB_LONG_US * `OGP_CLK_MHZ)

`endif

// ==== src/ogp_pkg.sv ====
// Types shared by the pin boot configuration block
package ogp_pkg;

    // ----------------------------------------------------------------
    // System signals that an output pin can carry, by function code
    // ----------------------------------------------------------------
    typedef struct packed {
        logic aux_reset;
        logic ext_power_clock;
        logic converter_power_good;
        logic supply_good;
        logic ext_power_enable2;
        logic ext_power_enable1;
        logic conv2_scaling_done;
        logic conv1_scaling_done;
        logic [2:0] reserved;
        logic power_state_change;
        logic sleep_state;
        logic on_state;
        logic osc_32k;
        logic gpio_value;
    } ogp_out_src_type;

    // ----------------------------------------------------------------
    // Requests that an input pin can raise, by function code
    // ----------------------------------------------------------------
    typedef struct packed {
        logic hw_control2_long;
        logic hw_control1_long;
        logic hw_control2;
        logic hw_control1;
        logic hw_enable2;
        logic hw_enable1;
        logic voltage_scaling_select2;
        logic voltage_scaling_select1;
        logic watchdog_reset;
        logic power_on_req;
        logic sleep_req;
        logic sleep_wake_long;
        logic sleep_wake_req;
        logic power_onoff_req;
        logic gpio_input;
        logic gpio_input_long;
    } ogp_in_req_type;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [17:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ogp_wb_req_type;

endpackage

// ==== src/ogp_debounce.sv ====
// Input debounce filter with a short and a long settling time
`timescale 1ns/1ps
module ogp_debounce import ogp_pkg::*; #(
    parameter int SHORT_CYC = 250,
    parameter int LONG_CYC = 2500000,
    parameter int CW = 22
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic raw,
    input wire logic long_sel,
    output logic level
);

    typedef struct packed {
        logic [CW-1:0] count;
        logic stable;
    } ogp_deb_state_type;

    ogp_deb_state_type s;
    ogp_deb_state_type next_s;
    logic [CW-1:0] limit;

    // Settling time picked by the pin function
    assign limit = long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

    // Level must hold unchanged for the whole interval before it is taken
    always_comb begin
        next_s = s;
        if (raw == s.stable) begin
            next_s.count = '0;
        end else if (s.count >= limit) begin
            next_s.stable = raw;
            next_s.count = '0;
        end else begin
            next_s.count = s.count + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.stable;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_deb_hold_change: assert property (
        ($changed(s.stable)) |-> ($past(s.count) >= $past(limit)))
        else $error("Debounced level changed before settling time");

endmodule // ogp_debounce

// ==== src/ogp_pin_config.sv ====
// Pin boot configuration registers, pin control, check word and supply good
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ogp_map.svh"
module ogp_pin_config import ogp_pkg::*; #(
    parameter int NPIN = 2,
    parameter int LONG_CYC = `OGP_DEB_LONG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire ogp_wb_req_type wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe_n,
    output logic [NPIN-1:0] pin_pull_up,
    output logic [NPIN-1:0] pin_pull_down,
    output logic [NPIN-1:0] pin_supply_domain,
    input wire ogp_out_src_type sys_src,
    output ogp_in_req_type in_req,
    input wire logic [12:0] main_supply_mv,
    output logic supply_good,
    input wire logic dev_mode,
    input wire logic on_request,
    output logic boot_config_valid
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cfg5;
        logic [15:0] cfg6;
        logic [15:0] check;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [NPIN-1:0] out_val;
        logic [NPIN-1:0] drive;
        logic [NPIN-1:0] oe_n;
        logic [NPIN-1:0] prev;
        logic [15:0] req;
        logic sup_good;
        logic cfg_valid;
        logic ack;
        logic [31:0] rdata;
    } ogp_cfg_state_type;

    localparam ogp_cfg_state_type ST_RST = '{
        cfg5: `OGP_PIN5_RST, cfg6: `OGP_PIN6_RST, check: `OGP_CHECK_RST,
        oe_n: '1, cfg_valid: 1'b1, default: '0};

    ogp_cfg_state_type s;
    ogp_cfg_state_type next_s;

    logic [15:0] cfg [NPIN];
    logic [NPIN-1:0] act;
    logic [NPIN-1:0] evt;
    logic [NPIN-1:0] drv_lvl;
    logic [NPIN-1:0] drv_en;
    logic [15:0] req_pin [NPIN];
    logic [15:0] req_all;
    logic [12:0] thr_mv;
    logic [15:0] wr_adr;
    logic bus_go;

    assign cfg[0] = s.cfg5;
    assign cfg[1] = s.cfg6;

    // ----------------------------------------------------------------
    // Per pin decode
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic [3:0] fn;
            logic is_in;
            logic ena;
            logic pol;
            logic od;
            logic long_fn;
            logic deb;
            logic [15:0] srcs;
            logic src;

            assign fn = cfg[g][`OGP_FN_HI:`OGP_FN_LO];
            assign is_in = cfg[g][`OGP_DIR_BIT];
            assign ena = cfg[g][`OGP_ENA_BIT];
            assign pol = cfg[g][`OGP_POL_BIT];
            assign od = cfg[g][`OGP_OD_BIT];
            // Long filter for codes 0, 4, 14 and 15
            assign long_fn = (fn == 4'h0) || (fn == 4'h4) || (fn == 4'he) || (fn == 4'hf);

            ogp_debounce #(
                .SHORT_CYC(`OGP_DEB_SHORT_CYC),
                .LONG_CYC(LONG_CYC),
                .CW(22)
            ) u_deb (
                .clk(clk),
                .rstn(rstn),
                .raw(pin_in[g]),
                .long_sel(long_fn),
                .level(deb)
            );

            // Active level after polarity
            assign act[g] = pol ? deb : ~deb;

            // One request line per input function code
            assign req_pin[g] = (ena && is_in && act[g]) ? (16'h0001 << fn) : 16'h0000;

            // Single edge on active level, or both edges
            assign evt[g] = ena && is_in && (cfg[g][`OGP_IRQ_MODE_BIT] ?
                (act[g] != s.prev[g]) : (act[g] && !s.prev[g]));

            // Output source by function code; reserved codes carry zero
            assign srcs = {sys_src[15:8], 3'b000, sys_src[4:1], s.out_val[g]};
            assign src = srcs[fn];
            assign drv_lvl[g] = pol ? src : ~src;
            // Open drain drives only the low level
            assign drv_en[g] = ena && !is_in && !(od && drv_lvl[g]);

            // Pull and supply selection; code 11 applies no pull
            assign pin_pull_down[g] = (cfg[g][`OGP_PULL_HI:`OGP_PULL_LO] == 2'b01);
            assign pin_pull_up[g] = (cfg[g][`OGP_PULL_HI:`OGP_PULL_LO] == 2'b10);
            assign pin_supply_domain[g] = cfg[g][`OGP_DOMAIN_BIT];
        end
    endgenerate

    // Requests from all pins merged
    always_comb begin
        req_all = '0;
        for (int i = 0; i < NPIN; i++) begin
            req_all = req_all | req_pin[i];
        end
    end

    // Rising threshold: base plus one step per code
    assign thr_mv = `OGP_THR_BASE_MV +
        13'(s.cfg6[`OGP_THR_HI:`OGP_THR_LO]) * `OGP_THR_STEP_MV;

    // ----------------------------------------------------------------
    // Bus and state update
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    assign wr_adr = wb_req.adr[17:2];
    assign bus_go = wb_req.cyc && wb_req.stb && !s.ack;

    always_comb begin
        logic [2:0] clr;
        logic [2:0] set;
        clr = '0;
        set = '0;
        next_s = s;
        next_s.ack = bus_go;
        next_s.rdata = '0;
        // Writes
        if (bus_go && wb_req.we) begin
            case (wr_adr)
                `OGP_IDX_PIN5: begin
                    next_s.cfg5 = merge16(s.cfg5, wb_req.dat, wb_req.sel) & `OGP_PIN5_MASK;
                end
                `OGP_IDX_PIN6: begin
                    next_s.cfg6 = merge16(s.cfg6, wb_req.dat, wb_req.sel) & `OGP_PIN6_MASK;
                end
                `OGP_IDX_CHECK: begin
                    next_s.check = merge16(s.check, wb_req.dat, wb_req.sel);
                end
                `OGP_IDX_IRQ_STAT: begin
                    clr = wb_req.sel[0] ? wb_req.dat[2:0] : 3'h0;
                end
                `OGP_IDX_IRQ_MASK: begin
                    if (wb_req.sel[0]) begin
                        next_s.irq_mask = wb_req.dat[2:0];
                    end
                end
                `OGP_IDX_PIN_OUT: begin
                    if (wb_req.sel[0]) begin
                        next_s.out_val = wb_req.dat[NPIN-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Reads; unmapped addresses read zero
        if (bus_go && !wb_req.we) begin
            case (wr_adr)
                `OGP_IDX_PIN5: next_s.rdata = {16'h0000, s.cfg5};
                `OGP_IDX_PIN6: next_s.rdata = {16'h0000, s.cfg6};
                `OGP_IDX_CHECK: next_s.rdata = {16'h0000, s.check};
                `OGP_IDX_IRQ_STAT: next_s.rdata = {29'h0, s.irq_stat};
                `OGP_IDX_IRQ_MASK: next_s.rdata = {29'h0, s.irq_mask};
                `OGP_IDX_PIN_OUT: next_s.rdata = {{(32 - NPIN){1'b0}}, s.out_val};
                `OGP_IDX_PIN_STATE: begin
                    next_s.rdata = {28'h0, s.cfg_valid, s.sup_good, act[1:0]};
                end
                default: next_s.rdata = '0;
            endcase
        end
        // Check word on an ON request in development mode
        if (on_request) begin
            next_s.cfg_valid = !dev_mode || (s.check == `OGP_CHECK_VALUE);
            set[2] = dev_mode && (s.check != `OGP_CHECK_VALUE);
        end
        // Supply good with hysteresis above the rising threshold
        if (main_supply_mv >= thr_mv + `OGP_HYST_MV) begin
            next_s.sup_good = 1'b1;
        end else if (main_supply_mv < thr_mv) begin
            next_s.sup_good = 1'b0;
        end
        // Sticky events; a new event beats a clear in the same cycle
        set[NPIN-1:0] = evt;
        next_s.irq_stat = (s.irq_stat & ~clr) | set;
        next_s.prev = act;
        next_s.req = req_all;
        next_s.drive = drv_lvl & ~{NPIN{1'b0}};
        for (int i = 0; i < NPIN; i++) begin
            next_s.drive[i] = cfg[i][`OGP_OD_BIT] ? 1'b0 : drv_lvl[i];
        end
        next_s.oe_n = ~drv_en;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign irq = |(s.irq_stat & s.irq_mask);
    assign pin_out = s.drive;
    assign pin_oe_n = s.oe_n;
    assign in_req = ogp_in_req_type'(s.req);
    assign supply_good = s.sup_good;
    assign boot_config_valid = s.cfg_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_single_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus ack held longer than one cycle");

    a_tristate_when_off: assert property (
        !s.cfg5[`OGP_ENA_BIT] ##1 !$past(s.cfg5[`OGP_ENA_BIT]) |-> pin_oe_n[0])
        else $error("Disabled pin is driven");

    a_input_not_driven: assert property (
        $past(s.cfg6[`OGP_DIR_BIT]) |-> pin_oe_n[1])
        else $error("Input pin is driven");

    a_od_high_release: assert property (
        $past(s.cfg6[`OGP_OD_BIT]) |-> (pin_out[1] == 1'b0))
        else $error("Open drain pin drives high");

    a_reserved_bit_zero: assert property (
        (s.cfg5[0] == 1'b0) && (s.cfg6[0] == 1'b0))
        else $error("Reserved pin word bit set");

    a_check_accept: assert property (
        (on_request && dev_mode && s.check == `OGP_CHECK_VALUE) |=> boot_config_valid)
        else $error("Valid check word rejected");

    a_check_reject: assert property (
        (on_request && dev_mode && s.check != `OGP_CHECK_VALUE)
        |=> (!boot_config_valid && s.irq_stat[2]))
        else $error("Bad check word accepted");

    a_supply_hyst: assert property (
        $rose(supply_good) |-> $past(main_supply_mv) >= $past(thr_mv) + `OGP_HYST_MV)
        else $error("Supply good rose below threshold plus margin");

    a_irq_set_wins: assert property (
        (evt[0] && s.cfg5[`OGP_ENA_BIT]) |=> s.irq_stat[0])
        else $error("Pin event lost");

    a_stat_sticky: assert property (
        (s.irq_stat[2] && !(bus_go && wb_req.we && wb_req.sel[0] && wb_req.dat[2]
            && (wr_adr == `OGP_IDX_IRQ_STAT))) |=> s.irq_stat[2])
        else $error("Status bit lost without a clear");

endmodule // ogp_pin_config

// ==== tb/ogp_board_model.sv ====
// Board-side model of the two pins: external drivers, pulls and floating wires
`timescale 1ns/1ps
module ogp_board_model (
    input wire logic clk,
    input wire logic [1:0] drv_en,
    input wire logic [1:0] drv_val,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] pin_pull_up,
    input wire logic [1:0] pin_pull_down,
    output logic [1:0] pin_in
);
    logic [1:0] last = 2'b00;

    // ----------------------------------------------------------------
    // Wire level resolution
    // ----------------------------------------------------------------
    // Device driver first, then board driver, then pulls
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (drv_en[i]) pin_in[i] = drv_val[i];
            else if (pin_pull_up[i]) pin_in[i] = 1'b1;
            else if (pin_pull_down[i]) pin_in[i] = 1'b0;
            else pin_in[i] = ~last[i]; // Undriven wire never holds a level
        end
    end

    // Last level, so a floating wire keeps changing
    always @(posedge clk) last <= pin_in;
endmodule // ogp_board_model

// ==== tb/ogp_pin_config_tb_top.sv ====
// Self-checking testbench of the pin boot configuration block
`timescale 1ns/1ps
`include "ogp_map.svh"
`define CHK(got, exp) check_eq(32'(got), 32'(exp), `__LINE__)
module ogp_pin_config_tb_top import ogp_pkg::*;;
    localparam int LONG = 600;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    ogp_wb_req_type wb_req = '0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, irq, supply_good, boot_config_valid;
    logic [1:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down, pin_supply_domain;
    logic [1:0] drv_en = 2'b01;
    logic [1:0] drv_val = 2'b00;
    ogp_out_src_type sys_src = '0;
    ogp_in_req_type in_req;
    logic [15:0] req_bits;
    logic [12:0] main_supply_mv = 13'h0000;
    logic dev_mode = 1'b0;
    logic on_request = 1'b0;
    int errors = 0;
    int comparisons = 0;

    // ----------------------------------------------------------------
    // Clock, design and board
    // ----------------------------------------------------------------
    always #2 clk = ~clk;
    assign req_bits = in_req;

    ogp_pin_config #(.NPIN(2), .LONG_CYC(LONG)) uut (.clk(clk), .rstn(rstn), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
        .pin_pull_down(pin_pull_down), .pin_supply_domain(pin_supply_domain),
        .sys_src(sys_src), .in_req(in_req), .main_supply_mv(main_supply_mv),
        .supply_good(supply_good), .dev_mode(dev_mode), .on_request(on_request),
        .boot_config_valid(boot_config_valid));

    ogp_board_model board (.clk(clk), .drv_en(drv_en), .drv_val(drv_val), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
        .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input int ln);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: line %0d got %h expected %h", $time, ln, got, exp);
        end
    endtask

    task automatic timeout();
        errors++;
        $display("mismatch at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    // Classic single Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h3,
                    dat: {16'h0000, d}};
        for (int i = 0; i <= 20; i++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
            if (i == 20) timeout();
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Cycles until a request bit (index 16 means irq) reaches a level
    task automatic wait_bit(input int c, input logic v, output int n);
        for (n = 0; n <= 1000; n++) begin
            if (((c == 16) ? irq : req_bits[c]) === v) break;
            if (n == 1000) timeout();
            @(posedge clk);
        end
    endtask

    task automatic pulse_on();
        @(posedge clk) on_request <= 1'b1;
        @(posedge clk) on_request <= 1'b0;
        tick(1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        tick(1);
        `CHK({pin_oe_n, boot_config_valid, supply_good}, 4'b1110);
        wb(0, `OGP_IDX_PIN5, 16'h0000);
        `CHK(rd, 32'h0000a400);
        wb(0, `OGP_IDX_PIN6, 16'h0000);
        `CHK(rd, 32'h0000a40a);
        wb(0, `OGP_IDX_CHECK, 16'h0000);
        `CHK(rd, 32'h00000000);
        wb(1, 16'h7900, 16'hffff);
        wb(0, 16'h7900, 16'h0000);
        `CHK(rd, 32'h00000000);
        wb(1, `OGP_IDX_PIN6, 16'hffff);
        wb(0, `OGP_IDX_PIN6, 16'h0000);
        `CHK(rd, 32'h0000fffe);
        $display("test reset done");
    endtask

    task automatic t_pull();
        for (int p = 0; p < 4; p++) begin
            wb(1, `OGP_IDX_PIN5, 16'({p[1:0], 1'b0, p[0], 11'h000}));
            tick(3);
            `CHK({pin_pull_up[0], pin_pull_down[0], pin_supply_domain[0]}, {p == 2, p == 1, p[0]});
        end
        $display("test pull done");
    endtask

    task automatic t_out();
        wb(1, `OGP_IDX_PIN_OUT, 16'h0002);
        for (int f = 0; f < 16; f++) begin
            wb(1, `OGP_IDX_PIN6, 16'h0500 | 16'(f << 4));
            @(posedge clk) sys_src <= ogp_out_src_type'(16'(1 << f));
            tick(3);
            `CHK({pin_oe_n[1], pin_out[1]}, {1'b0, f < 5 || f > 7});
            @(posedge clk) sys_src <= '0;
            tick(3);
            `CHK({pin_oe_n[1], pin_out[1]}, {1'b0, f == 0});
        end
        wb(1, `OGP_IDX_PIN6, 16'h0100);
        tick(3);
        `CHK({pin_oe_n[1], pin_out[1]}, 2'b00);
        wb(1, `OGP_IDX_PIN6, 16'h0700);
        tick(3);
        `CHK({pin_oe_n[1], pin_out[1]}, 2'b10);
        wb(1, `OGP_IDX_PIN_OUT, 16'h0000);
        tick(3);
        `CHK({pin_oe_n[1], pin_out[1]}, 2'b00);
        wb(1, `OGP_IDX_PIN6, 16'h0400);
        tick(3);
        `CHK(pin_oe_n[1], 1'b1);
        wb(1, `OGP_IDX_PIN6, 16'h8500);
        tick(3);
        `CHK(pin_oe_n[1], 1'b1);
        $display("test outputs done");
    endtask

    task automatic t_in();
        int n;
        int lo;
        for (int c = 0; c < 16; c++) begin
            lo = (c == 0 || c == 4 || c == 14 || c == 15) ? LONG : 250;
            wb(1, `OGP_IDX_PIN5, 16'h8500 | 16'(c << 4));
            @(posedge clk) drv_val <= 2'b01;
            wait_bit(c, 1'b1, n);
            `CHK(n >= lo && n <= lo + 6, 1'b1);
            @(posedge clk) drv_val <= 2'b00;
            wait_bit(c, 1'b0, n);
        end
        $display("test inputs done");
    endtask

    task automatic t_irq();
        int n;
        wb(1, `OGP_IDX_IRQ_MASK, 16'h0001);
        wb(1, `OGP_IDX_IRQ_STAT, 16'h0007);
        wb(1, `OGP_IDX_PIN5, 16'h8510);
        @(posedge clk) drv_val <= 2'b01;
        wait_bit(16, 1'b1, n);
        wb(0, `OGP_IDX_IRQ_STAT, 16'h0000);
        `CHK(rd, 32'h00000001);
        wb(1, `OGP_IDX_IRQ_STAT, 16'h0001);
        tick(1);
        `CHK(irq, 1'b0);
        @(posedge clk) drv_val <= 2'b00;
        tick(300);
        `CHK(irq, 1'b0);
        wb(1, `OGP_IDX_PIN5, 16'h9510);
        @(posedge clk) drv_val <= 2'b01;
        wait_bit(16, 1'b1, n);
        wb(1, `OGP_IDX_IRQ_STAT, 16'h0001);
        @(posedge clk) drv_val <= 2'b00;
        wait_bit(16, 1'b1, n);
        `CHK(n >= 250 && n <= 256, 1'b1);
        wb(1, `OGP_IDX_IRQ_MASK, 16'h0000);
        tick(1);
        `CHK(irq, 1'b0);
        wb(1, `OGP_IDX_IRQ_STAT, 16'h0007);
        $display("test interrupt done");
    endtask

    task automatic t_supply();
        int off[4] = '{-1, `OGP_HYST_MV - 1, `OGP_HYST_MV, -1};
        logic ex[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        int thr;
        for (int t = 0; t < 8; t++) begin
            thr = `OGP_THR_BASE_MV + `OGP_THR_STEP_MV * t;
            wb(1, `OGP_IDX_PIN6, 16'h8400 | 16'(t << 1));
            for (int k = 0; k < 4; k++) begin
                @(posedge clk) main_supply_mv <= 13'(thr + off[k]);
                tick(3);
                `CHK(supply_good, ex[k]);
            end
        end
        $display("test supply good done");
    endtask

    task automatic t_check();
        @(posedge clk) dev_mode <= 1'b1;
        pulse_on();
        `CHK(boot_config_valid, 1'b0);
        wb(0, `OGP_IDX_IRQ_STAT, 16'h0000);
        `CHK(rd[2], 1'b1);
        wb(1, `OGP_IDX_CHECK, 16'ha597);
        pulse_on();
        `CHK(boot_config_valid, 1'b0);
        wb(1, `OGP_IDX_CHECK, 16'ha596);
        pulse_on();
        `CHK(boot_config_valid, 1'b1);
        wb(0, `OGP_IDX_PIN_STATE, 16'h0000);
        `CHK(rd[3], 1'b1);
        $display("test check word done");
    endtask

    // Reset for four cycles, then every scenario in turn
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_pull();
        t_out();
        t_in();
        t_irq();
        t_supply();
        t_check();
        tally_and_finish();
    end
endmodule // ogp_pin_config_tb_top
